// File: rtl/ebpc_ctrl_reg.sv
// Bank switch control register holding the keeper enable bit
`timescale 1ns/100ps
`default_nettype none
`include "ebpc_defs.svh"

module ebpc_ctrl_reg (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Core write port
    input wire logic wr_i,
    input wire logic keeper_bit_i,
    // State
    output logic bus_keeper_enable_bit_o
);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bus_keeper_enable_bit_o <= `EBPC_KEEPER_RST;
        end else if (wr_i) begin
            bus_keeper_enable_bit_o <= keeper_bit_i;
        end
    end

endmodule

`default_nettype wire

// File: rtl/ebpc_defs.svh
// Constants of the external bus pin control block
`ifndef EBPC_DEFS_SVH
`define EBPC_DEFS_SVH

`define EBPC_ADDR_W 20
`define EBPC_LOW_ADDR_W 16
`define EBPC_DATA_W 16
`define EBPC_KEEPER_RST 1'b0
`define EBPC_SPACE_PROG 2'h0
`define EBPC_SPACE_DATA 2'h1
`define EBPC_SPACE_IO 2'h2

`endif

// File: rtl/ebpc_keep_if.sv
// Data pin keeper carrier between top and keeper module
`timescale 1ns/100ps
`default_nettype none
`include "ebpc_defs.svh"

interface ebpc_keep_if;
    logic [`EBPC_DATA_W-1:0] pin_level;
    logic enable;
    logic [`EBPC_DATA_W-1:0] held;
    logic held_oe;

    modport owner (output pin_level, output enable, input held, input held_oe);
    modport keeper (input pin_level, input enable, output held, output held_oe);
endinterface

`default_nettype wire

// File: rtl/ebpc_keeper.sv
// Bus keeper: remembers the last data bus level
`timescale 1ns/100ps
`default_nettype none
`include "ebpc_defs.svh"

module ebpc_keeper (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Carrier
    ebpc_keep_if.keeper kp
);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            kp.held <= '0;
        end else begin
            kp.held <= kp.pin_level;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            kp.held_oe <= 1'b0;
        end else begin
            kp.held_oe <= kp.enable;
        end
    end

endmodule

`default_nettype wire

// File: rtl/ebpc_pkg.sv
// Types of the external bus pin control block
package ebpc_pkg;

    typedef enum logic [1:0] {
        EBPC_SP_PROG = 2'h0,
        EBPC_SP_DATA = 2'h1,
        EBPC_SP_IO = 2'h2
    } ebpc_space_t;

    // Gray-coded bus owner states
    typedef enum logic [1:0] {
        EBPC_ST_IDLE = 2'h0,
        EBPC_ST_ADDR = 2'h1,
        EBPC_ST_DATA = 2'h3,
        EBPC_ST_HOLD = 2'h2
    } ebpc_state_t;

endpackage

// File: rtl/ebpc_top.sv
// External bus pin control: address, data, grant and acknowledge pins
// ****************************************************************
// ****************************************************************
`timescale 1ns/100ps
`default_nettype none
`include "ebpc_defs.svh"

module ebpc_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Core access request
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [1:0] req_space_i,
    input wire logic [`EBPC_ADDR_W-1:0] req_addr_i,
    input wire logic [`EBPC_DATA_W-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic [`EBPC_DATA_W-1:0] rdata_o,
    output logic rdata_valid_o,
    // Interrupt vector fetch
    input wire logic vec_fetch_i,
    input wire logic [`EBPC_LOW_ADDR_W-1:0] vec_addr_i,
    // Keeper bit write
    input wire logic ctrl_wr_i,
    input wire logic ctrl_keeper_i,
    output logic bus_keeper_enable_bit_o,
    // Pins
    input wire logic float_n_i,
    input wire logic bus_request_n_i,
    output logic [`EBPC_ADDR_W-1:0] addr_o,
    output logic [`EBPC_ADDR_W-1:0] addr_oe_o,
    input wire logic [`EBPC_DATA_W-1:0] data_i,
    output logic [`EBPC_DATA_W-1:0] data_o,
    output logic [`EBPC_DATA_W-1:0] data_oe_o,
    output logic interrupt_acknowledge_out_n_o,
    output logic interrupt_acknowledge_out_oe_o,
    output logic bus_grant_output_n_o,
    output logic bus_grant_output_oe_o
);

    ebpc_pkg::ebpc_state_t state_q;
    ebpc_pkg::ebpc_state_t state_d;
    logic write_q;
    logic interrupt_acknowledge_out_q;
    logic [`EBPC_ADDR_W-1:0] next_addr;
    logic take;
    logic read_end;
    logic [`EBPC_DATA_W-1:0] wdata_q;
    logic keeper_en;
    logic start;
    logic float_now;
    logic data_drive_d;

    ebpc_keep_if kif ();

    // ****************************************************************
    // Address formation
    // ****************************************************************
    function automatic logic [`EBPC_ADDR_W-1:0] form_addr(input logic [1:0] space,
                                                           input logic [`EBPC_ADDR_W-1:0] a);
        if (space == `EBPC_SPACE_PROG) begin
            form_addr = a;
        end else begin
            form_addr = {4'h0, a[`EBPC_LOW_ADDR_W-1:0]};
        end
    endfunction

    function automatic logic [`EBPC_DATA_W-1:0] fill16(input logic b);
        fill16 = {`EBPC_DATA_W{b}};
    endfunction

    // ****************************************************************
    // Bus owner state machine
    // ****************************************************************
    assign start = (req_i || vec_fetch_i) && bus_request_n_i;
    assign float_now = !float_n_i;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ebpc_pkg::EBPC_ST_IDLE: begin
                if (!bus_request_n_i) begin
                    state_d = ebpc_pkg::EBPC_ST_HOLD;
                end else if (start) begin
                    state_d = ebpc_pkg::EBPC_ST_ADDR;
                end
            end
            ebpc_pkg::EBPC_ST_ADDR: begin
                state_d = ebpc_pkg::EBPC_ST_DATA;
            end
            ebpc_pkg::EBPC_ST_DATA: begin
                state_d = ebpc_pkg::EBPC_ST_IDLE;
            end
            ebpc_pkg::EBPC_ST_HOLD: begin
                if (bus_request_n_i) begin
                    state_d = ebpc_pkg::EBPC_ST_IDLE;
                end
            end
            default: begin
                state_d = ebpc_pkg::EBPC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= ebpc_pkg::EBPC_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Access latch
    // ****************************************************************
    assign take = state_q == ebpc_pkg::EBPC_ST_IDLE && state_d == ebpc_pkg::EBPC_ST_ADDR;
    assign read_end = state_q == ebpc_pkg::EBPC_ST_DATA && !write_q;

    // Vector fetch wins over a plain access and only uses the low lines
    assign next_addr = vec_fetch_i ? {4'h0, vec_addr_i} : form_addr(req_space_i, req_addr_i);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            write_q <= 1'b0;
        end else if (take) begin
            write_q <= req_write_i && !vec_fetch_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            interrupt_acknowledge_out_q <= 1'b0;
        end else if (take) begin
            interrupt_acknowledge_out_q <= vec_fetch_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wdata_q <= '0;
        end else if (take) begin
            wdata_q <= req_wdata_i;
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            req_ready_o <= 1'b0;
        end else begin
            req_ready_o <= take;
        end
    end

    // Loaded even under float so the value is fresh when the pins return
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            addr_o <= '0;
        end else if (take) begin
            addr_o <= next_addr;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            addr_oe_o <= '0;
        end else if (state_d == ebpc_pkg::EBPC_ST_HOLD || float_now) begin
            addr_oe_o <= '0;
        end else if (state_d == ebpc_pkg::EBPC_ST_ADDR || state_d == ebpc_pkg::EBPC_ST_DATA) begin
            addr_oe_o <= '1;
        end else begin
            addr_oe_o <= '0;
        end
    end

    // Drive data only in the write data phase
    assign data_drive_d = state_d == ebpc_pkg::EBPC_ST_DATA && write_q && bus_request_n_i && !float_now;

    // Pin level as the keeper sees it
    assign kif.pin_level = data_oe_o[0] ? data_o : (kif.held_oe ? kif.held : data_i);
    assign kif.enable = keeper_en;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            data_o <= '0;
        end else if (data_drive_d) begin
            data_o <= wdata_q;
        end else if (keeper_en && !float_now) begin
            data_o <= kif.pin_level;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            data_oe_o <= '0;
        end else if (data_drive_d) begin
            data_oe_o <= fill16(1'b1);
        end else begin
            data_oe_o <= '0;
        end
    end

    // ****************************************************************
    // Read capture
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_valid_o <= 1'b0;
        end else begin
            rdata_valid_o <= read_end;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (read_end) begin
            rdata_o <= data_i;
        end
    end

    // ****************************************************************
    // Acknowledge and grant pins
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            interrupt_acknowledge_out_oe_o <= 1'b0;
        end else begin
            interrupt_acknowledge_out_oe_o <= !float_now;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            interrupt_acknowledge_out_n_o <= 1'b1;
        end else begin
            interrupt_acknowledge_out_n_o <= !(state_d == ebpc_pkg::EBPC_ST_DATA && interrupt_acknowledge_out_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bus_grant_output_oe_o <= 1'b0;
        end else begin
            bus_grant_output_oe_o <= !float_now;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bus_grant_output_n_o <= 1'b1;
        end else begin
            bus_grant_output_n_o <= state_d != ebpc_pkg::EBPC_ST_HOLD;
        end
    end

    // ****************************************************************
    // Keeper enable register and keeper
    // ****************************************************************
    ebpc_ctrl_reg u_ctrl (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(ctrl_wr_i),
        .keeper_bit_i(ctrl_keeper_i),
        .bus_keeper_enable_bit_o(keeper_en)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bus_keeper_enable_bit_o <= `EBPC_KEEPER_RST;
        end else begin
            bus_keeper_enable_bit_o <= keeper_en;
        end
    end

    ebpc_keeper u_keep (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .kp(kif.keeper)
    );

endmodule

`default_nettype wire

// File: tb/ebpc_mem_model.sv
// Memory and I/O devices on the far side of the bus
`timescale 1ns/100ps
`default_nettype none
module ebpc_mem_model (
    // Clock
    input wire logic clk_i,
    // Pins seen from the far side
    input wire logic [19:0] addr_i,
    input wire logic addr_oe_i,
    input wire logic [15:0] dq_i,
    input wire logic dq_oe_i,
    input wire logic keep_i,
    output logic [15:0] dq_o,
    output logic [19:0] last_addr_o
);
    logic [15:0] mem [16];
    logic [15:0] last_q = 16'h0;
    always @(posedge clk_i) begin
        if (dq_oe_i) begin
            mem[addr_i[3:0]] <= dq_i;
            last_addr_o <= addr_i;
        end
        last_q <= dq_o;
    end
    // A released unkept line toggles every cycle so no stale level passes
    always_comb begin
        if (dq_oe_i) dq_o = dq_i;
        else if (addr_oe_i) dq_o = mem[addr_i[3:0]];
        else if (keep_i) dq_o = dq_i;
        else dq_o = ~last_q;
    end
endmodule
`default_nettype wire

// File: tb/ebpc_monitor.sv
// Checker of the external bus pin control ports
`timescale 1ns/100ps
`default_nettype none
`include "ebpc_defs.svh"
module ebpc_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Core side
    input wire logic [1:0] req_space_i,
    input wire logic [`EBPC_ADDR_W-1:0] req_addr_i,
    input wire logic req_ready_o,
    input wire logic vec_fetch_i,
    input wire logic [`EBPC_LOW_ADDR_W-1:0] vec_addr_i,
    input wire logic ctrl_wr_i,
    input wire logic ctrl_keeper_i,
    input wire logic bus_keeper_enable_bit_o,
    // Pins
    input wire logic float_n_i,
    input wire logic bus_request_n_i,
    input wire logic [`EBPC_ADDR_W-1:0] addr_o,
    input wire logic [`EBPC_ADDR_W-1:0] addr_oe_o,
    input wire logic [`EBPC_DATA_W-1:0] data_oe_o,
    input wire logic interrupt_acknowledge_out_n_o,
    input wire logic interrupt_acknowledge_out_oe_o,
    input wire logic bus_grant_output_n_o,
    input wire logic bus_grant_output_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_addr;
        req_ready_o && $past(float_n_i) && !$past(vec_fetch_i) |-> addr_oe_o == 20'hFFFFF && addr_o ==
            ($past(req_space_i) == 2'h0 ? $past(req_addr_i) : {4'h0, $past(req_addr_i[15:0])});
    endproperty
    a_addr: assert property (p_addr) else $error("address lines wrong for space");
    property p_hold;
        !bus_grant_output_n_o |-> addr_oe_o == 20'h0 && data_oe_o == 16'h0;
    endproperty
    a_hold: assert property (p_hold) else $error("lines driven during hold");
    property p_float;
        !float_n_i |=> addr_oe_o == 20'h0 && data_oe_o == 16'h0 && !interrupt_acknowledge_out_oe_o
            && !bus_grant_output_oe_o;
    endproperty
    a_float: assert property (p_float) else $error("pins driven while float low");
    property p_pin_oe;
        $past(rst_n_i) && $past(float_n_i) |-> interrupt_acknowledge_out_oe_o && bus_grant_output_oe_o;
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("grant or acknowledge not driven");
    property p_wr_phase;
        $rose(data_oe_o[0]) |-> $past(req_ready_o) && data_oe_o == 16'hFFFF ##1 data_oe_o == 16'h0;
    endproperty
    a_wr_phase: assert property (p_wr_phase) else $error("data drive outside write phase");
    property p_interrupt_acknowledge_out;
        !interrupt_acknowledge_out_n_o |-> addr_o[15:0] == $past(vec_addr_i, 2) ##1 interrupt_acknowledge_out_n_o;
    endproperty
    a_interrupt_acknowledge_out: assert property (p_interrupt_acknowledge_out) else $error("acknowledge without vector address");
    property p_grant;
        $fell(bus_grant_output_n_o) |-> !$past(bus_request_n_i);
    endproperty
    a_grant: assert property (p_grant) else $error("grant without request");
    property p_keeper;
        ctrl_wr_i |-> ##2 bus_keeper_enable_bit_o == $past(ctrl_keeper_i, 2);
    endproperty
    a_keeper: assert property (p_keeper) else $error("keeper bit not written");
endmodule
`default_nettype wire

// File: tb/ebpc_top_tb.sv
// Self-checking bench of the external bus pin control block
`timescale 1ns/100ps
`default_nettype none
`include "ebpc_defs.svh"
module ebpc_top_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_i = 1'b0, req_write_i = 1'b0, vec_fetch_i = 1'b0, ctrl_wr_i = 1'b0, ctrl_keeper_i = 1'b0;
    logic float_n_i = 1'b1, bus_request_n_i = 1'b1;
    logic [1:0] req_space_i = 2'h0;
    logic [19:0] req_addr_i = 20'h0, addr_o, addr_oe_o, last_addr;
    logic [15:0] req_wdata_i = 16'h0, vec_addr_i = 16'h0, rdata_o, data_i, data_o, data_oe_o, got;
    logic req_ready_o, rdata_valid_o, bus_keeper_enable_bit_o, interrupt_acknowledge_out_n_o;
    logic interrupt_acknowledge_out_oe_o, bus_grant_output_n_o, bus_grant_output_oe_o;
    logic [15:0] wd [16];
    logic [19:0] wa [16];
    int n_errors = 0, n_tests = 0;
    always #4 clk_i = ~clk_i;
    ebpc_top DUT (.clk_i, .rst_n_i, .req_i, .req_write_i, .req_space_i, .req_addr_i, .req_wdata_i, .req_ready_o,
        .rdata_o, .rdata_valid_o, .vec_fetch_i, .vec_addr_i, .ctrl_wr_i, .ctrl_keeper_i, .bus_keeper_enable_bit_o,
        .float_n_i, .bus_request_n_i, .addr_o, .addr_oe_o, .data_i, .data_o, .data_oe_o,
        .interrupt_acknowledge_out_n_o, .interrupt_acknowledge_out_oe_o, .bus_grant_output_n_o,
        .bus_grant_output_oe_o);
    ebpc_mem_model MEM (.clk_i(clk_i), .addr_i(addr_o), .addr_oe_i(addr_oe_o[0]), .dq_i(data_o),
        .dq_oe_i(data_oe_o[0]), .keep_i(bus_keeper_enable_bit_o), .dq_o(data_i), .last_addr_o(last_addr));
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] seen);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [19:0] exp_addr(input logic [1:0] sp, input logic [19:0] a);
        return (sp == 2'h0) ? a : {4'h0, a[15:0]};
    endfunction
    task automatic access(input logic wr, input logic [1:0] sp, input logic [19:0] a, input logic [15:0] d,
        input logic vec);
        int k;
        @(posedge clk_i);
        req_write_i <= wr;
        req_space_i <= sp;
        req_addr_i <= a;
        req_wdata_i <= d;
        vec_addr_i <= a[15:0];
        vec_fetch_i <= vec;
        req_i <= ~vec;
        k = 0;
        do begin @(posedge clk_i); k++; end while (req_ready_o !== 1'b1 && k < 20);
        req_i <= 1'b0;
        vec_fetch_i <= 1'b0;
        chk("req_ready_o", 20'h1, {19'h0, req_ready_o});
        if (wr) repeat (2) @(posedge clk_i);
        else begin
            k = 0;
            do begin @(posedge clk_i); k++; end while (rdata_valid_o !== 1'b1 && k < 6);
            chk("rdata_valid_o", 20'h1, {19'h0, rdata_valid_o});
            got = rdata_o;
        end
    endtask
    task automatic keeper_wr(input logic b);
        @(posedge clk_i);
        ctrl_wr_i <= 1'b1;
        ctrl_keeper_i <= b;
        @(posedge clk_i);
        ctrl_wr_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("keeper_bit", {19'h0, b}, {19'h0, bus_keeper_enable_bit_o});
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        $display("ERROR watchdog expected end seen timeout");
        end_sim();
    end
    initial begin
        logic [1:0] sp;
        void'($urandom(32'h9915719F));
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        chk("reset_oe", 20'h0, addr_oe_o | {4'h0, data_oe_o});
        chk("reset_keeper", 20'h0, {19'h0, bus_keeper_enable_bit_o});
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            sp = 2'(i % 3);
            wa[i] = {16'($urandom), i[3:0]};
            wd[i] = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
            access(1'b1, sp, wa[i], wd[i], 1'b0);
            chk("write_addr", exp_addr(sp, wa[i]), last_addr);
        end
        for (int i = 0; i < 16; i++) begin
            access(1'b0, 2'(i % 3), wa[i], 16'h0, 1'b0);
            chk("read_data", {4'h0, wd[i]}, {4'h0, got});
        end
        $display("test write and read done");
        access(1'b0, 2'h0, 20'h0FF85, 16'h0, 1'b1);
        chk("vector_data", {4'h0, wd[5]}, {4'h0, got});
        $display("test vector fetch done");
        keeper_wr(1'b1);
        access(1'b1, 2'h1, 20'h0003A, 16'hA5C3, 1'b0);
        repeat (2) @(posedge clk_i);
        chk("kept_level", 20'h0A5C3, {4'h0, data_i});
        chk("idle_data_oe", 20'h0, {4'h0, data_oe_o});
        keeper_wr(1'b0);
        $display("test keeper done");
        @(posedge clk_i);
        bus_request_n_i <= 1'b0;
        req_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("hold_grant_n", 20'h0, {19'h0, bus_grant_output_n_o});
        chk("hold_oe", 20'h0, addr_oe_o | {4'h0, data_oe_o} | {19'h0, req_ready_o});
        bus_request_n_i <= 1'b1;
        req_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("release_grant_n", 20'h1, {19'h0, bus_grant_output_n_o});
        $display("test hold done");
        float_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("float_oe", 20'h0, addr_oe_o | {4'h0, data_oe_o} | {18'h0, interrupt_acknowledge_out_oe_o,
            bus_grant_output_oe_o});
        float_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        $display("test float done");
        end_sim();
    end
endmodule
bind ebpc_top ebpc_monitor MON (.clk_i, .rst_n_i, .req_space_i, .req_addr_i, .req_ready_o, .vec_fetch_i,
    .vec_addr_i, .ctrl_wr_i, .ctrl_keeper_i, .bus_keeper_enable_bit_o, .float_n_i, .bus_request_n_i, .addr_o,
    .addr_oe_o, .data_oe_o, .interrupt_acknowledge_out_n_o, .interrupt_acknowledge_out_oe_o,
    .bus_grant_output_n_o, .bus_grant_output_oe_o);
`default_nettype wire
